// ==== ewp_core.sv ====
// serial write-protect core: frame decode, status bits, write guard and apb view
//
// Functional notes
// RULE1: status write changes only the protect-enable bit and both block-protect bits.
// RULE2: block-protect 00 none, 01 1800h-1FFFh, 10 1000h-1FFFh, 11 whole array.
// RULE3: hardware-protect enable is status bit 7, only gating the protect pin.
// RULE4: hardware protection on when protect pin low and enable bit set.
// RULE5: hardware protection off when pin high or enable bit clear.
// RULE6: hardware protection refuses status writes only, never array writes.
// RULE7: latch clear blocks all; set allows unprotected blocks and unguarded status.
// RULE8: write latch is cleared by power-up reset.
// RULE9: host sends latch-set command before each write; nothing else sets latch.
// RULE10: latch clears after every completed array or status write.
// RULE11: write starts only when deselect follows an exact command length.
// RULE12: array accesses during an internal write are ignored, cycle continues.
// RULE13: after reset: deselected, latch clear, serial output not driven.
// RULE14: internal write needs the latch; set and clear commands drive it.
// RULE15: block-protect bits readable at status bits 3 and 2 anytime.
// RULE16: busy bit 0 is high exactly while an internal write runs.
// RULE17: status write is opcode then one data byte, msb first, select held.
// RULE18: data for bits 6 to 4, latch and busy positions is ignored.
`timescale 1ns/100ps
module ewp_core (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire ewp_pkg::ewp_apb_req_t apb_in,
  output ewp_pkg::ewp_apb_rsp_t apb_out,
  input wire ewp_pkg::ewp_spi_pins_t spi_in,
  output logic so_out,
  output logic so_oe_out,
  output logic commit_out,
  output logic [12:0] commit_addr_out,
  output logic [7:0] sr_out
);
  import ewp_pkg::*;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sck_d;
    logic cs_d;
    logic [7:0] shift;
    logic [15:0] bitcnt;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic hwpe;
    logic [1:0] bp;
    logic write_latch_flag;
    logic busy;
    logic [15:0] busy_cnt;
    logic so;
    logic so_oe;
    logic commit;
    logic [12:0] commit_addr;
    logic [15:0] wtime;
    logic refused;
    logic abandoned;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ewp_state_t;

  localparam ewp_state_t STATE_RST = '{
    sync1: SYNC_RST, sync2: SYNC_RST, sck_d: 1'b0, cs_d: 1'b1,
    shift: 8'h00, bitcnt: 16'h0000, opcode: 8'h00, addr: 16'h0000,
    hwpe: HWPE_RST, bp: BP_RST, write_latch_flag: 1'b0, busy: 1'b0, busy_cnt: 16'h0000,
    so: 1'b0, so_oe: 1'b0, commit: 1'b0, commit_addr: 13'h0000,
    wtime: WTIME_RST, refused: 1'b0, abandoned: 1'b0,
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000
  };

  ewp_state_t r;
  ewp_state_t n;

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic byte_aligned;
  logic hw_prot;
  logic array_ok;
  logic status_ok;
  logic [7:0] sr_now;
  logic [7:0] in_byte;
  logic [15:0] cnt_inc;
  logic [15:0] wload;
  logic apb_access;
  logic apb_done;

  // only the second synchroniser stage and its delayed copy are looked at
  assign cs_low = !r.sync2[SY_CS];
  assign cs_fall = !r.sync2[SY_CS] && r.cs_d;
  assign cs_rise = r.sync2[SY_CS] && !r.cs_d;
  assign sck_rise = r.sync2[SY_SCK] && !r.sck_d;
  assign sck_fall = !r.sync2[SY_SCK] && r.sck_d;
  assign byte_aligned = (r.bitcnt[2:0] == BYTE_PHASE0);
  assign sr_now = {r.hwpe, SR_UNUSED, r.bp, r.write_latch_flag, r.busy}; // [RULE3] [RULE15] [RULE16]
  assign in_byte = {r.shift[6:0], r.sync2[SY_SI]};
  assign cnt_inc = (r.bitcnt == BITS_MAX) ? r.bitcnt : r.bitcnt + CNT_ONE;
  // a zero duration would make busy invisible, so one cycle is the floor
  assign wload = (r.wtime < CNT_ONE) ? CNT_ONE : r.wtime;
  assign apb_access = apb_in.psel && apb_in.penable;
  assign apb_done = apb_access && r.pready;

  ewp_guard u_guard (
    .wel_in(r.write_latch_flag),
    .hwpe_in(r.hwpe),
    .bp_in(r.bp),
    .wp_n_in(r.sync2[SY_WP]),
    .addr_in(r.addr[12:0]),
    .hw_prot_out(hw_prot),
    .array_ok_out(array_ok),
    .status_ok_out(status_ok)
  );

  always_comb begin
    n = r;
    n.sync1 = {spi_in.wp_n, spi_in.si, spi_in.sck, spi_in.cs_n};
    n.sync2 = r.sync1;
    n.sck_d = r.sync2[SY_SCK];
    n.cs_d = r.sync2[SY_CS];
    n.commit = 1'b0;

    // apb: one wait state, write lands on the completing edge
    n.pready = apb_access && !r.pready;
    if (apb_access && !r.pready) begin
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
      case (apb_in.paddr)
        ADDR_STATUS: begin
          n.prdata[7:0] = sr_now; // [RULE15] [RULE16]
          n.prdata[ST_HWPROT] = hw_prot;
          n.prdata[ST_WPPIN] = r.sync2[SY_WP];
        end
        ADDR_CTRL: n.prdata[15:0] = r.wtime;
        ADDR_EVENT: begin
          n.prdata[EV_REFUSED] = r.refused;
          n.prdata[EV_ABANDON] = r.abandoned;
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    if (apb_done && apb_in.pwrite) begin
      case (apb_in.paddr)
        ADDR_CTRL: n.wtime = apb_in.pwdata[15:0];
        ADDR_EVENT: begin
          // clears come first so a same-cycle event below still sets
          if (apb_in.pwdata[EV_REFUSED]) begin
            n.refused = 1'b0;
          end
          if (apb_in.pwdata[EV_ABANDON]) begin
            n.abandoned = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // internal write timer
    if (r.busy) begin
      if (r.busy_cnt <= CNT_ONE) begin
        n.busy = 1'b0; // [RULE16]
        n.busy_cnt = 16'h0000;
      end else begin
        n.busy_cnt = r.busy_cnt - CNT_ONE;
      end
    end

    // serial frame: sample on rising clock, shift status out on falling
    if (cs_fall) begin
      n.bitcnt = 16'h0000;
      n.opcode = 8'h00;
    end else if (cs_low && sck_rise) begin
      n.shift = in_byte; // [RULE17]
      n.bitcnt = cnt_inc;
      if (cnt_inc == BITS_OPCODE) begin
        n.opcode = in_byte;
      end
      if (cnt_inc == BITS_ADDR_HI) begin
        n.addr[15:8] = in_byte;
      end
      if (cnt_inc == BITS_ADDR_LO) begin
        n.addr[7:0] = in_byte;
      end
    end
    if (cs_low && sck_fall && r.opcode == OP_STATUS_READ && r.bitcnt >= BITS_OPCODE) begin
      n.so = sr_now[~r.bitcnt[2:0]]; // [RULE15]
      n.so_oe = 1'b1;
    end

    if (cs_rise) begin
      n.so_oe = 1'b0; // [RULE13]
      case (r.opcode)
        OP_LATCH_SET: begin
          if (r.bitcnt == BITS_OPCODE) begin
            n.write_latch_flag = 1'b1; // [RULE14]
          end else begin
            n.abandoned = 1'b1;
          end
        end
        OP_LATCH_CLEAR: begin
          if (r.bitcnt == BITS_OPCODE) begin
            n.write_latch_flag = 1'b0; // [RULE14]
          end else begin
            n.abandoned = 1'b1;
          end
        end
        OP_STATUS_WRITE: begin
          if (r.busy) begin
            n.refused = 1'b1;
          end else if (r.bitcnt != BITS_STATUS_WRITE) begin
            n.abandoned = 1'b1; // [RULE11] [RULE17]
          end else if (status_ok) begin
            // only the nonvolatile bits are taken from the data byte
            n.hwpe = r.shift[SR_HWPE]; // [RULE1] [RULE18]
            n.bp = {r.shift[SR_BP_HI], r.shift[SR_BP_LO]}; // [RULE1] [RULE18]
            n.write_latch_flag = 1'b0; // [RULE10]
            n.busy = 1'b1;
            n.busy_cnt = wload;
          end else begin
            n.refused = 1'b1; // [RULE6] [RULE7]
          end
        end
        OP_ARRAY_WRITE: begin
          if (r.busy) begin
            n.refused = 1'b1; // [RULE12]
          end else if (r.bitcnt < BITS_FIRST_DATA || !byte_aligned) begin
            n.abandoned = 1'b1; // [RULE11]
          end else if (array_ok) begin
            n.commit = 1'b1; // [RULE14]
            n.commit_addr = r.addr[12:0];
            n.write_latch_flag = 1'b0; // [RULE10]
            n.busy = 1'b1;
            n.busy_cnt = wload;
          end else begin
            n.refused = 1'b1; // [RULE2] [RULE7]
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= STATE_RST; // [RULE8] [RULE13]
    end else begin
      r <= n;
    end
  end

  assign apb_out = '{pready: r.pready, pslverr: r.pslverr, prdata: r.prdata};
  assign so_out = r.so;
  assign so_oe_out = r.so_oe;
  assign commit_out = r.commit;
  assign commit_addr_out = r.commit_addr;
  assign sr_out = {r.hwpe, SR_UNUSED, r.bp, r.write_latch_flag, r.busy};

  property p_wel_cleared_by_write;
    @(posedge clk_in) disable iff (!arst_n_in) $rose(r.busy) |-> !r.write_latch_flag && r.busy_cnt == $past(wload);
  endproperty
  a_wel_cleared_by_write: assert property (p_wel_cleared_by_write) // [RULE10]
    else $error("latch not cleared or wrong duration at write start");

  property p_status_guarded;
    @(posedge clk_in) disable iff (!arst_n_in)
      $changed({r.hwpe, r.bp}) |-> $past(cs_rise && r.write_latch_flag && !hw_prot && r.bitcnt == BITS_STATUS_WRITE);
  endproperty
  a_status_guarded: assert property (p_status_guarded) // [RULE6]
    else $error("status bits changed without a permitted status write");

  property p_block_decode;
    @(posedge clk_in) disable iff (!arst_n_in) r.commit |-> !ewp_blocked($past(r.bp), r.commit_addr);
  endproperty
  a_block_decode: assert property (p_block_decode) // [RULE2]
    else $error("array write committed into a protected block");

  property p_commit_needs_latch;
    @(posedge clk_in) disable iff (!arst_n_in) r.commit |-> $past(r.write_latch_flag) && r.busy;
  endproperty
  a_commit_needs_latch: assert property (p_commit_needs_latch) // [RULE14]
    else $error("array write committed without the latch");

  property p_commit_on_deselect;
    @(posedge clk_in) disable iff (!arst_n_in)
      r.commit |-> $past(cs_rise && byte_aligned && r.bitcnt >= BITS_FIRST_DATA);
  endproperty
  a_commit_on_deselect: assert property (p_commit_on_deselect) // [RULE11]
    else $error("array write committed without an exact deselect");

  property p_no_commit_when_busy;
    @(posedge clk_in) disable iff (!arst_n_in) r.busy ##1 r.busy |-> !r.commit;
  endproperty
  a_no_commit_when_busy: assert property (p_no_commit_when_busy) // [RULE12]
    else $error("array write accepted during an internal write");

  property p_busy_ends;
    @(posedge clk_in) disable iff (!arst_n_in) r.busy && r.busy_cnt == CNT_ONE |=> !r.busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) // [RULE16]
    else $error("busy flag outlived its write cycle");

  property p_hw_prot_off;
    @(posedge clk_in) disable iff (!arst_n_in) (r.sync2[SY_WP] || !r.hwpe) |-> !hw_prot;
  endproperty
  a_hw_prot_off: assert property (p_hw_prot_off) // [RULE5]
    else $error("hardware protection active with pin high or enable clear");

  property p_latch_set_by_cmd;
    @(posedge clk_in) disable iff (!arst_n_in)
      $rose(r.write_latch_flag) |-> $past(cs_rise && r.opcode == OP_LATCH_SET && r.bitcnt == BITS_OPCODE);
  endproperty
  a_latch_set_by_cmd: assert property (p_latch_set_by_cmd) // [RULE14]
    else $error("latch set by something other than a latch-set command");

  property p_so_quiet;
    @(posedge clk_in) disable iff (!arst_n_in) r.so_oe |-> r.opcode == OP_STATUS_READ && !r.cs_d;
  endproperty
  a_so_quiet: assert property (p_so_quiet) // [RULE13]
    else $error("serial output driven outside a status read");
endmodule : ewp_core

// ==== ewp_pkg.sv ====
// package: constants, carriers and decode helper for the eeprom write-protect block
package ewp_pkg;
  // serial command opcodes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  // status register bit positions
  localparam int SR_BUSY = 0;
  localparam int SR_LATCH = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 3;
  localparam int SR_HWPE = 7;
  localparam logic [2:0] SR_UNUSED = 3'h0;
  // block-protect codes and first protected address of the quarter and half codes
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [12:0] BLK_QUARTER_BASE = 13'h1800;
  localparam logic [12:0] BLK_HALF_BASE = 13'h1000;
  // frame bit counts
  localparam logic [15:0] BITS_OPCODE = 16'h0008;
  localparam logic [15:0] BITS_STATUS_WRITE = 16'h0010;
  localparam logic [15:0] BITS_ADDR_HI = 16'h0010;
  localparam logic [15:0] BITS_ADDR_LO = 16'h0018;
  localparam logic [15:0] BITS_FIRST_DATA = 16'h0020;
  localparam logic [15:0] BITS_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [2:0] BYTE_PHASE0 = 3'h0;
  // synchroniser lanes
  localparam int SY_CS = 0;
  localparam int SY_SCK = 1;
  localparam int SY_SI = 2;
  localparam int SY_WP = 3;
  localparam logic [3:0] SYNC_RST = 4'h9;
  // apb register map
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_EVENT = 12'h008;
  localparam int ST_HWPROT = 8;
  localparam int ST_WPPIN = 9;
  localparam int EV_REFUSED = 0;
  localparam int EV_ABANDON = 1;
  localparam logic [15:0] WTIME_RST = 16'h0400;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic HWPE_RST = 1'b0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } ewp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ewp_apb_rsp_t;

  typedef struct packed {
    logic wp_n;
    logic si;
    logic sck;
    logic cs_n;
  } ewp_spi_pins_t;

  // true when the address lies in a block that the code protects
  function automatic logic ewp_blocked(input logic [1:0] bp, input logic [12:0] addr);
    logic hit;
    hit = 1'b1;
    case (bp)
      BP_NONE: hit = 1'b0;
      BP_QUARTER: hit = (addr >= BLK_QUARTER_BASE);
      BP_HALF: hit = (addr >= BLK_HALF_BASE);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : ewp_blocked
endpackage : ewp_pkg

// ==== ewp_guard.sv ====
// permission matrix: latch, block-protect and hardware-protect decisions
`timescale 1ns/100ps
module ewp_guard (
  input wire logic wel_in,
  input wire logic hwpe_in,
  input wire logic [1:0] bp_in,
  input wire logic wp_n_in,
  input wire logic [12:0] addr_in,
  output logic hw_prot_out,
  output logic array_ok_out,
  output logic status_ok_out
);
  import ewp_pkg::*;

  assign hw_prot_out = hwpe_in && !wp_n_in; // [RULE3] [RULE4] [RULE5]
  // hardware protection never touches the array path
  assign array_ok_out = wel_in && !ewp_blocked(bp_in, addr_in); // [RULE2] [RULE6] [RULE7]
  assign status_ok_out = wel_in && !hw_prot_out; // [RULE6] [RULE7]
endmodule : ewp_guard

// ==== ewp_spi_host.sv ====
// spi host model that frames command bits towards the write-protect core
`timescale 1ns/100ps
module ewp_spi_host (
  input logic so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out
);
  localparam time HALF = 24ns;
  // bits seen on the returning line, taken on each rising serial clock
  logic [39:0] rx;
  initial begin
    rx = '0;
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end
  // select low for the whole frame, msb first, mode 0
  task automatic send(input logic [39:0] d, input int n);
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_out = d[i];
      #HALF sck_out = 1'b1;
      rx = {rx[38:0], so_in};
      #HALF sck_out = 1'b0;
    end
    #HALF cs_n_out = 1'b1;
    // deselected: inverted bit so a stale value never looks valid
    si_out = ~si_out;
    #(4 * HALF);
  endtask : send
endmodule : ewp_spi_host

// ==== tb.sv ====
// testbench: apb and serial frames against the write-protect core
`timescale 1ns/100ps
module tb;
  import ewp_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n = 1'b0;
  logic wp_n = 1'b1;
  logic cs_n, sck, si, so, so_oe, commit;
  logic [12:0] caddr;
  logic [7:0] sr;
  ewp_apb_req_t apb_q = '0;
  ewp_apb_rsp_t apb_rsp;
  ewp_spi_pins_t spi;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_commit = 0;
  logic [12:0] last_addr;
  logic [31:0] rd;
  logic err;
  logic [12:0] addrs [4] = '{13'h0fff, 13'h1000, 13'h17ff, 13'h1800};
  assign spi = {wp_n, si, sck, cs_n};
  initial forever #2.5 clk_in = ~clk_in;
  ewp_core i_ewp_core (
    .clk_in(clk_in),
    .arst_n_in(arst_n),
    .apb_in(apb_q),
    .apb_out(apb_rsp),
    .spi_in(spi),
    .so_out(so),
    .so_oe_out(so_oe),
    .commit_out(commit),
    .commit_addr_out(caddr),
    .sr_out(sr)
  );
  // released data line reads as its pull-up level
  ewp_spi_host i_ewp_spi_host (
    .so_in(so_oe ? so : 1'b1),
    .cs_n_out(cs_n),
    .sck_out(sck),
    .si_out(si)
  );
  always @(posedge clk_in) begin
    cycles++;
    if (commit === 1'b1) begin
      n_commit++;
      last_addr = caddr;
    end
    if (cycles == 40000) begin
      n_errors++;
      $display("unexpected timeout exp done got hang");
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_in);
    apb_q.penable <= 1'b1;
    @(posedge clk_in);
    while (apb_rsp.pready !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 100) begin
      n_errors++;
      $display("unexpected pready exp 1 got 0");
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_q <= '0;
    @(posedge clk_in);
  endtask : apb
  task automatic ev_chk(input logic [31:0] e);
    apb(1'b0, ADDR_EVENT, 32'h0);
    chk("event", e, rd);
    apb(1'b1, ADDR_EVENT, 32'h3);
  endtask : ev_chk
  task automatic cmd8(input logic [7:0] op);
    i_ewp_spi_host.send({32'h0, op}, 8);
  endtask : cmd8
  task automatic status_write_cmd(input logic [7:0] v);
    i_ewp_spi_host.send({24'h0, OP_STATUS_WRITE, v}, 16);
  endtask : status_write_cmd
  task automatic awr(input logic [12:0] a);
    i_ewp_spi_host.send({8'h0, OP_ARRAY_WRITE, 3'h0, a, 8'h5a}, 32);
  endtask : awr
  task automatic wait_idle();
    for (int i = 0; i < 5000 && sr[SR_BUSY] !== 1'b0; i++) @(posedge clk_in);
    chk("idle", 0, sr[SR_BUSY]);
  endtask : wait_idle
  task automatic set_wp(input logic v);
    @(posedge clk_in);
    wp_n <= v;
    repeat (4) @(posedge clk_in);
  endtask : set_wp
  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, n_errors);
  endtask : done
  initial begin
    logic blk;
    int nc;
    repeat (16) @(posedge clk_in);
    arst_n <= 1'b1;
    @(posedge clk_in);
    chk("sr_reset", 0, sr);
    chk("so_oe", 0, so_oe);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_reset", WTIME_RST, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 1, err);
    // long enough that busy still stands when a frame task returns
    apb(1'b1, ADDR_CTRL, 32'h0000_0040);
    done("reset");
    status_write_cmd(8'h8c);
    chk("sr_no_latch", 0, sr);
    ev_chk(32'h1);
    cmd8(OP_LATCH_SET);
    chk("latch_set", 32'h02, sr);
    cmd8(OP_LATCH_CLEAR);
    chk("latch_clear", 32'h00, sr);
    cmd8(OP_LATCH_SET);
    status_write_cmd(8'hf2);
    chk("sr_busy", 32'h81, sr);
    wait_idle();
    chk("sr_done", 32'h80, sr);
    done("latch");
    set_wp(1'b0);
    cmd8(OP_LATCH_SET);
    status_write_cmd(8'h00);
    chk("sr_hw_prot", 32'h82, sr);
    ev_chk(32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("hw_prot_flag", 1, rd[ST_HWPROT]);
    chk("wp_pin", 0, rd[ST_WPPIN]);
    nc = n_commit;
    awr(13'h1abc);
    chk("commit_hw", 1, n_commit - nc);
    chk("commit_addr", 13'h1abc, last_addr);
    wait_idle();
    set_wp(1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("hw_prot_off", 0, rd[ST_HWPROT]);
    cmd8(OP_LATCH_SET);
    status_write_cmd(8'h00);
    wait_idle();
    chk("sr_clear", 32'h00, sr);
    done("hw_protect");
    for (int b = 0; b < 4; b++) begin
      cmd8(OP_LATCH_SET);
      status_write_cmd({4'h0, b[1:0], 2'h0});
      wait_idle();
      chk("bp_bits", b, sr[SR_BP_HI:SR_BP_LO]);
      for (int k = 0; k < 4; k++) begin
        nc = n_commit;
        cmd8(OP_LATCH_SET);
        awr(addrs[k]);
        wait_idle();
        blk = (b == 3) || (b == 2 && addrs[k] >= 13'h1000) || (b == 1 && addrs[k] >= 13'h1800);
        chk("commit_bp", !blk, n_commit - nc);
        chk("latch_after", blk, sr[SR_LATCH]);
        ev_chk(blk);
        cmd8(OP_LATCH_CLEAR);
      end
    end
    cmd8(OP_LATCH_SET);
    status_write_cmd(8'h00);
    wait_idle();
    done("blocks");
    nc = n_commit;
    cmd8(OP_LATCH_SET);
    i_ewp_spi_host.send({4'h0, OP_ARRAY_WRITE, 16'h0010, 8'ha5, 4'h3}, 36);
    i_ewp_spi_host.send({31'h0, OP_LATCH_CLEAR, 1'b0}, 9);
    chk("abandon_commit", 0, n_commit - nc);
    chk("abandon_sr", 32'h02, sr);
    ev_chk(32'h2);
    done("abandon");
    apb(1'b1, ADDR_CTRL, 32'h0000_03e8);
    awr(13'h0040);
    cmd8(OP_LATCH_SET);
    awr(13'h0080);
    chk("busy_commit", 1, n_commit - nc);
    chk("busy_addr", 13'h0040, last_addr);
    chk("still_busy", 1, sr[SR_BUSY]);
    i_ewp_spi_host.send({24'h0, OP_STATUS_READ, 8'h00}, 16);
    chk("status_read", 32'h03, i_ewp_spi_host.rx[7:0]);
    chk("so_oe_end", 0, so_oe);
    ev_chk(32'h1);
    wait_idle();
    done("busy");
    summarize();
  end
endmodule : tb
